// File: src/rtctsm_regs.vh
/*
  Register offsets, field positions, reset values and timing counts for the
  trim and supply monitor block. Definitions only; included by bare name.
*/
`ifndef RTCTSM_REGS_VH
`define RTCTSM_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define RTCTSM_OFS_TRIM 4'h0
`define RTCTSM_OFS_CTRL1 4'h1
`define RTCTSM_OFS_CTRL2 4'h2
`define RTCTSM_OFS_IRQ_STAT 4'h3
`define RTCTSM_OFS_IRQ_MASK 4'h4
`define RTCTSM_OFS_STATUS 4'h5

// ----------------------------------------------------------------------------
// control 1 fields
// ----------------------------------------------------------------------------
`define RTCTSM_C1_WEEKDAY_ALARM_ENABLE 7
`define RTCTSM_C1_DAILY_ALARM_ENABLE 6
`define RTCTSM_C1_SPARE3 5
`define RTCTSM_C1_HOUR24 4
`define RTCTSM_C1_TEST 3

// ----------------------------------------------------------------------------
// control 2 fields
// ----------------------------------------------------------------------------
`define RTCTSM_C2_VSEL 7
`define RTCTSM_C2_HALT 6
`define RTCTSM_C2_LOWV 5
`define RTCTSM_C2_SPARE1 4
`define RTCTSM_C2_SPARE2 3
`define RTCTSM_C2_PFLAG 2
`define RTCTSM_C2_WFLAG 1
`define RTCTSM_C2_DFLAG 0

// ----------------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------------
`define RTCTSM_IRQ_HALT 0
`define RTCTSM_IRQ_LOWV 1
`define RTCTSM_IRQ_SEC 2

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define RTCTSM_TRIM_RST 7'h00
`define RTCTSM_CTRL1_RST 8'h00
`define RTCTSM_CTRL2_RST 8'h40
`define RTCTSM_OSC_PER_SEC 32768
`define RTCTSM_TRIM_INTERVAL_S 20
`define RTCTSM_TRIM_STEP 2
`define RTCTSM_CLK_PERIOD_NS 20
`define RTCTSM_SAMPLE_WIN_NS 7800000
`define RTCTSM_SAMPLE_WIN_CYC ((`RTCTSM_SAMPLE_WIN_NS + `RTCTSM_CLK_PERIOD_NS - 1) / `RTCTSM_CLK_PERIOD_NS)

`endif

// File: src/rtctsm_tick_gen.v
/*
  Derives the 1-second tick from 32.768 kHz oscillator ticks, stretching or
  shortening one second in every trim interval by the trim code.
  Assumes osc_tick_i is a one-cycle pulse per oscillator period.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtctsm_regs.vh"

module rtctsm_tick_gen #(
  parameter BASE_CYCLES = `RTCTSM_OSC_PER_SEC,
  parameter INTERVAL = `RTCTSM_TRIM_INTERVAL_S,
  parameter STEP = `RTCTSM_TRIM_STEP
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire osc_tick_i,
  input wire [6:0] trim_code_i,
  output reg sec_tick_o,
  output reg [4:0] sec_phase_o
);

  // --------------------------------------------------------------------------
  // trim decode
  // --------------------------------------------------------------------------
  function signed [17:0] trim_delta;
    input [6:0] code;
    begin
      if (code[5:1] == 5'h00) begin
        trim_delta = 18'sd0;
      end else if (!code[6]) begin
        trim_delta = $signed(STEP[17:0]) * ($signed({11'h000, code}) - 18'sd1);
      end else begin
        trim_delta = -($signed(STEP[17:0]) * (18'sd128 - $signed({11'h000, code})));
      end
    end
  endfunction

  reg [17:0] count_reg;
  wire signed [17:0] period_w;
  // only the first second of the interval is corrected
  assign period_w = (sec_phase_o == 5'h00) ? ($signed(BASE_CYCLES[17:0]) + trim_delta(trim_code_i)) :
    $signed(BASE_CYCLES[17:0]);

  // --------------------------------------------------------------------------
  // counters
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    sec_tick_o <= 1'b0;
    if (sys_rst_i) begin
      count_reg <= 18'h00000;
      sec_phase_o <= 5'h00;
    end else if (osc_tick_i) begin
      if (count_reg >= period_w[17:0] - 18'h00001) begin
        count_reg <= 18'h00000;
        sec_tick_o <= 1'b1;
        sec_phase_o <= (sec_phase_o == INTERVAL - 1) ? 5'h00 : sec_phase_o + 5'h01;
      end else begin
        count_reg <= count_reg + 18'h00001;
      end
    end
  end

endmodule // rtctsm_tick_gen
`default_nettype wire

// File: src/rtctsm_supply_mon.v
/*
  Supply monitor: opens a sampling window after each second tick while low_flag_i is low, and reports
  a low supply seen at the window's close. Assumes comparator inputs are
  valid while sample_en_o is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtctsm_regs.vh"

module rtctsm_supply_mon #(
  parameter WIN_CYC = `RTCTSM_SAMPLE_WIN_CYC
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire sec_tick_i,
  input wire low_flag_i,
  input wire thresh_sel_i,
  input wire below_2v1_i,
  input wire below_1v6_i,
  output reg sample_en_o,
  output reg low_detect_o
);

  reg [19:0] win_reg;
  wire below_w;
  assign below_w = thresh_sel_i ? below_1v6_i : below_2v1_i;

  // --------------------------------------------------------------------------
  // sampling window
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    low_detect_o <= 1'b0;
    if (sys_rst_i || low_flag_i) begin
      // comparator stays off while a drop is already recorded, saving current
      sample_en_o <= 1'b0;
      win_reg <= 20'h00000;
    end else if (sec_tick_i) begin
      sample_en_o <= 1'b1;
      win_reg <= WIN_CYC[19:0] - 20'h00001;
    end else if (sample_en_o) begin
      if (win_reg == 20'h00000) begin
        sample_en_o <= 1'b0;
        low_detect_o <= below_w;
      end else begin
        win_reg <= win_reg - 20'h00001;
      end
    end
  end

endmodule // rtctsm_supply_mon
`default_nettype wire

// File: src/rtctsm_top.v
/*
  Trim and supply health logic of a real-time clock: trimmed 1-second tick,
  oscillator-halt and low-supply flags, control bits, Avalon-MM register
  slave with one wait state, and an interrupt output.
  Assumes all inputs are synchronous to ref_clk_i.
*/
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
// Summary of operation
// - once per 20-second interval one 1-second tick is lengthened or shortened to correct timekeeping.
// - the trim is a 7-bit two's-complement code and codes 0, +1, -64, -63 apply no correction.
// - positive codes 2 to 63 slow the count by code minus one steps of about 3.05 ppm.
// - codes 7fh down to 42h speed the count by 80h minus code steps of about 3.05 ppm.
// - the 32.768 kHz clock output is never altered by the trim.
// - halt and low-supply flags set on their event and stay set until software writes 0.
// - setting the halt flag clears the low-supply flag.
// - setting the halt flag clears trim, alarm enables, periodic select, format, test, threshold, spares and flags.
// - power-up reset sets the halt flag.
// - threshold select 0 picks the 2.1 V level and 1 picks 1.6 V.
// - the supply is sampled in a 7.8 ms window once a second and a drop sets the low-supply flag.
// - sampling stops while the low-supply flag is set.
`timescale 1ns/1ps
`default_nettype none
`include "rtctsm_regs.vh"

module rtctsm_top #(
  parameter SAMPLE_WIN_CYC = `RTCTSM_SAMPLE_WIN_CYC,
  parameter OSC_PER_SEC = `RTCTSM_OSC_PER_SEC
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // oscillator and supply
  input wire osc_level_i,
  input wire osc_tick_i,
  input wire osc_halt_i,
  input wire supply_below_2v1_i,
  input wire supply_below_1v6_i,
  output wire supply_sample_en_o,
  output wire clock_out_32k_o,
  output wire sec_tick_o,
  output wire irq_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg [6:0] trim_code_bits_reg;
  reg [7:0] ctrl1_reg;
  reg [7:0] ctrl2_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg [31:0] rdata_reg;
  reg done_reg;
  reg clk32_reg;

  reg [6:0] trim_next;
  reg [7:0] ctrl1_next;
  reg [7:0] ctrl2_next;
  reg [2:0] irq_stat_next;

  wire sec_tick_w;
  wire [4:0] sec_phase_w;
  wire low_detect_w;
  wire bus_req_w;
  wire wr_fire_w;
  wire rd_start_w;
  wire osc_halt_flag;
  wire low_supply_flag;
  wire supply_threshold_select;
  wire [2:0] irq_event_w;

  assign osc_halt_flag = ctrl2_reg[`RTCTSM_C2_HALT];
  assign low_supply_flag = ctrl2_reg[`RTCTSM_C2_LOWV];
  assign supply_threshold_select = ctrl2_reg[`RTCTSM_C2_VSEL];

  // --------------------------------------------------------------------------
  // bus handshake: one wait state per access
  // --------------------------------------------------------------------------
  assign bus_req_w = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = bus_req_w & ~done_reg;
  assign wr_fire_w = avs_write_i & done_reg;
  assign rd_start_w = avs_read_i & ~done_reg;
  assign avs_readdata_o = rdata_reg;

  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= bus_req_w & ~done_reg;
    end
  end

  // --------------------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------------------
  rtctsm_tick_gen #(
    .BASE_CYCLES(OSC_PER_SEC),
    .INTERVAL(`RTCTSM_TRIM_INTERVAL_S),
    .STEP(`RTCTSM_TRIM_STEP)
  ) u_tick (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .osc_tick_i(osc_tick_i),
    .trim_code_i(trim_code_bits_reg),
    .sec_tick_o(sec_tick_w),
    .sec_phase_o(sec_phase_w)
  );

  rtctsm_supply_mon #(
    .WIN_CYC(SAMPLE_WIN_CYC)
  ) u_mon (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sec_tick_i(sec_tick_w),
    .low_flag_i(low_supply_flag),
    .thresh_sel_i(supply_threshold_select),
    .below_2v1_i(supply_below_2v1_i),
    .below_1v6_i(supply_below_1v6_i),
    .sample_en_o(supply_sample_en_o),
    .low_detect_o(low_detect_w)
  );

  assign sec_tick_o = sec_tick_w;

  // --------------------------------------------------------------------------
  // 32 khz output: straight copy of the oscillator, trim never reaches it
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      clk32_reg <= 1'b0;
    end else begin
      clk32_reg <= osc_level_i;
    end
  end
  assign clock_out_32k_o = clk32_reg;

  // --------------------------------------------------------------------------
  // register and flag next state
  // --------------------------------------------------------------------------
  always @* begin
    trim_next = trim_code_bits_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    if (wr_fire_w) begin
      case (avs_address_i)
        `RTCTSM_OFS_TRIM: begin
          trim_next = avs_writedata_i[6:0];
        end
        `RTCTSM_OFS_CTRL1: begin
          ctrl1_next = avs_writedata_i[7:0];
        end
        `RTCTSM_OFS_CTRL2: begin
          // halt and low-supply flags accept only a clearing write
          ctrl2_next = avs_writedata_i[7:0];
          ctrl2_next[`RTCTSM_C2_HALT] = ctrl2_reg[`RTCTSM_C2_HALT] & avs_writedata_i[`RTCTSM_C2_HALT];
          ctrl2_next[`RTCTSM_C2_LOWV] = ctrl2_reg[`RTCTSM_C2_LOWV] & avs_writedata_i[`RTCTSM_C2_LOWV];
        end
        default: begin
          trim_next = trim_code_bits_reg;
        end
      endcase
    end
    // a detection in the same cycle as a clearing write wins
    if (low_detect_w) begin
      ctrl2_next[`RTCTSM_C2_LOWV] = 1'b1;
    end
    if (osc_halt_i) begin
      trim_next = 7'h00;
      ctrl1_next = 8'h00;
      ctrl2_next = 8'h00;
      ctrl2_next[`RTCTSM_C2_HALT] = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status: write one to clear, new events win
  // --------------------------------------------------------------------------
  assign irq_event_w = {sec_tick_w, low_detect_w & ~osc_halt_i, osc_halt_i};

  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_fire_w && avs_address_i == `RTCTSM_OFS_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~avs_writedata_i[2:0];
    end
    irq_stat_next = irq_stat_next | irq_event_w;
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      // power-up from a dead supply leaves the halt flag set
      trim_code_bits_reg <= `RTCTSM_TRIM_RST;
      ctrl1_reg <= `RTCTSM_CTRL1_RST;
      ctrl2_reg <= `RTCTSM_CTRL2_RST;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      trim_code_bits_reg <= trim_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      irq_stat_reg <= irq_stat_next;
      if (wr_fire_w && avs_address_i == `RTCTSM_OFS_IRQ_MASK) begin
        irq_mask_reg <= avs_writedata_i[2:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // read data, captured on the wait cycle so it stands at the accept edge
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_start_w) begin
      case (avs_address_i)
        `RTCTSM_OFS_TRIM: begin
          rdata_reg <= {25'h0000000, trim_code_bits_reg};
        end
        `RTCTSM_OFS_CTRL1: begin
          rdata_reg <= {24'h000000, ctrl1_reg};
        end
        `RTCTSM_OFS_CTRL2: begin
          rdata_reg <= {24'h000000, ctrl2_reg};
        end
        `RTCTSM_OFS_IRQ_STAT: begin
          rdata_reg <= {29'h00000000, irq_stat_reg};
        end
        `RTCTSM_OFS_IRQ_MASK: begin
          rdata_reg <= {29'h00000000, irq_mask_reg};
        end
        `RTCTSM_OFS_STATUS: begin
          rdata_reg <= {26'h0000000, supply_sample_en_o, sec_phase_w};
        end
        default: begin
          rdata_reg <= 32'h00000000;
        end
      endcase
    end
  end

endmodule // rtctsm_top
`default_nettype wire

// File: tb/rtctsm_top_properties.sv
/*
  checker for rtctsm_top: tick length, trim spacing, clock pin copy, supply window, bus wait state.
  assumes it is bound to rtctsm_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module rtctsm_top_properties #(
  parameter SAMPLE_WIN_CYC = 8,
  parameter OSC_PER_SEC = 200
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire osc_level_i,
  input wire osc_tick_i,
  input wire osc_halt_i,
  input wire supply_below_2v1_i,
  input wire supply_below_1v6_i,
  input wire supply_sample_en_o,
  input wire clock_out_32k_o,
  input wire sec_tick_o,
  input wire irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------------------------------
  // helper counters: oscillator ticks per second, seconds since an odd one
  // ----------------------------------------------------------------
  int osc_n;
  int odd_gap;
  int win_n;
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      osc_n <= 0;
      odd_gap <= 20;
      win_n <= 0;
    end else begin
      if (sec_tick_o) begin
        osc_n <= int'(osc_tick_i);
        odd_gap <= (osc_n != OSC_PER_SEC) ? 1 : ((odd_gap < 20) ? odd_gap + 1 : 20);
      end else if (osc_tick_i) begin
        osc_n <= osc_n + 1;
      end
      win_n <= supply_sample_en_o ? win_n + 1 : 0;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  odd_spacing_a: assert property (sec_tick_o && osc_n != OSC_PER_SEC |-> odd_gap >= 20)
    else $error("two corrected seconds within one trim interval");
  sec_len_a: assert property (sec_tick_o |-> osc_n >= OSC_PER_SEC - 126 && osc_n <= OSC_PER_SEC + 124)
    else $error("second length outside the trim range");
  tick_cause_a: assert property (sec_tick_o |-> $past(osc_tick_i) ##1 !sec_tick_o)
    else $error("second tick not a single pulse after an oscillator tick");
  clk_out_a: assert property (!$past(sys_rst_i) |-> clock_out_32k_o == $past(osc_level_i))
    else $error("clock output differs from oscillator level");
  sample_start_a: assert property ($rose(supply_sample_en_o) |-> $past(sec_tick_o))
    else $error("sampling window opened without a second tick");
  sample_len_a: assert property ($fell(supply_sample_en_o) |-> win_n == SAMPLE_WIN_CYC)
    else $error("sampling window has the wrong length");
  wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus request not answered after one wait state");
  idle_wait_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest high while idle");
  upper_zero_a: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  cover property ($fell(supply_sample_en_o));
  cover property (sec_tick_o && osc_n != OSC_PER_SEC);
  cover property ($rose(irq_o));
endmodule // rtctsm_top_properties
bind rtctsm_top rtctsm_top_properties #(.SAMPLE_WIN_CYC(SAMPLE_WIN_CYC), .OSC_PER_SEC(OSC_PER_SEC)) props_u (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .osc_level_i(osc_level_i), .osc_tick_i(osc_tick_i),
  .osc_halt_i(osc_halt_i), .supply_below_2v1_i(supply_below_2v1_i), .supply_below_1v6_i(supply_below_1v6_i),
  .supply_sample_en_o(supply_sample_en_o), .clock_out_32k_o(clock_out_32k_o), .sec_tick_o(sec_tick_o),
  .irq_o(irq_o));
`default_nettype wire

// File: tb/rtc_trim_and_supply_monitor_tb.sv
/*
  bench for rtctsm_top: register model, halt, supply monitor, irq and trimmed second sums.
  assumes the dut is built with short second and window counts.
*/
`timescale 1ns/1ps
`default_nettype none
module rtc_trim_and_supply_monitor_tb;
  localparam int OPS = 200;
  localparam int WIN = 8;
  logic ref_clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0, osc_level_i = 0, osc_tick_i = 0;
  logic osc_halt_i = 0, supply_below_2v1_i = 0, supply_below_1v6_i = 0;
  logic [3:0] avs_address_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic [31:0] q;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, supply_sample_en_o, clock_out_32k_o, sec_tick_o, irq_o;
  int errors = 0, n_tests = 0, seed = 32'h92cf, osc_cnt = 0, se_cnt = 0, c0 = 0;
  int mdl [0:5];
  // codes as software would compute them from a fast or slow oscillator
  int codes [$] = '{'h00, 'h01, 'h40, 'h41, 'h02, 'h3f, 'h7f, 'h42};
  rtctsm_top #(.SAMPLE_WIN_CYC(WIN), .OSC_PER_SEC(OPS)) dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .osc_level_i(osc_level_i), .osc_tick_i(osc_tick_i), .osc_halt_i(osc_halt_i),
    .supply_below_2v1_i(supply_below_2v1_i), .supply_below_1v6_i(supply_below_1v6_i),
    .supply_sample_en_o(supply_sample_en_o), .clock_out_32k_o(clock_out_32k_o), .sec_tick_o(sec_tick_o),
    .irq_o(irq_o));
  always #10 ref_clk_i = ~ref_clk_i;
  // ----------------------------------------------------------------
  // oscillator: a tick every second clock, random level on the pin
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    osc_tick_i <= ~osc_tick_i;
    osc_level_i <= 1'($random(seed));
    if (osc_tick_i) osc_cnt <= osc_cnt + 1;
    if (supply_sample_en_o === 1'b1) se_cnt <= se_cnt + 1;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a slow answer is waited for up to 50 cycles, a missing one is counted as an error
  task bus(input logic [3:0] a, input logic w, input logic [31:0] dt);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_writedata_i <= dt;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) errors++;
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] dt);
    bus(a, 1'b1, dt);
    case (a)
      0: mdl[0] = dt & 'h7f;
      1: mdl[1] = dt & 'hff;
      2: mdl[2] = (dt & 'h9f) | (mdl[2] & dt & 'h60);
      3: mdl[3] = mdl[3] & ~dt;
      4: mdl[4] = dt & 'h7;
      default: ;
    endcase
  endtask
  // second-tick bit of the interrupt status is not modelled, so it is masked off
  task rdc(input logic [3:0] a);
    bus(a, 1'b0, 32'h0);
    chk(q & ((a == 3) ? 32'h3 : 32'hffffffff), (a < 5) ? mdl[a] : 0);
  endtask
  task tick(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(negedge ref_clk_i);
        n++;
      end while (sec_tick_o !== 1'b1 && n < 4 * OPS);
      if (sec_tick_o !== 1'b1) errors++;
    end
  endtask
  task drv(input logic v21, input logic v16);
    @(posedge ref_clk_i);
    supply_below_2v1_i <= v21;
    supply_below_1v6_i <= v16;
  endtask
  function int dlt(input int c);
    if (c[5:1] == 0) return 0;
    return (c < 64) ? 2 * (c - 1) : -2 * (128 - c);
  endfunction
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    errors++;
    results;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mdl = '{0, 0, 'h40, 0, 0, 0};
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a < 16; a++) if (a != 5) rdc(4'(a));
    for (int a = 0; a < 10; a++) begin
      if (a != 5) begin
        wr(4'(a), $random(seed));
        rdc(4'(a));
      end
    end
    wr(2, 0);
    rdc(2);
    $display("test registers done");
    wr(4, 0);
    wr(3, 7);
    wr(1, 'hff);
    wr(0, 'h55);
    wr(2, 'hbf);
    @(posedge ref_clk_i);
    osc_halt_i <= 1'b1;
    @(posedge ref_clk_i);
    osc_halt_i <= 1'b0;
    mdl[0] = 0;
    mdl[1] = 0;
    mdl[2] = 'h40;
    mdl[3] |= 1;
    @(negedge ref_clk_i);
    chk(irq_o, 0);
    for (int a = 0; a < 4; a++) rdc(4'(a));
    wr(4, 1);
    chk(irq_o, 1);
    wr(3, 1);
    chk(irq_o, 0);
    $display("test halt done");
    wr(4, 2);
    wr(2, 'h80);
    drv(1, 0);
    tick(3);
    rdc(2);
    chk(irq_o, 0);
    drv(1, 1);
    tick(3);
    mdl[2] |= 'h20;
    mdl[3] |= 2;
    rdc(2);
    chk(irq_o, 1);
    c0 = se_cnt;
    tick(2);
    chk(se_cnt - c0, 0);
    drv(0, 0);
    wr(2, 'h80);
    wr(3, 2);
    chk(irq_o, 0);
    c0 = se_cnt;
    tick(2);
    chk(se_cnt - c0 >= WIN, 1);
    wr(2, 0);
    drv(1, 0);
    tick(3);
    mdl[2] |= 'h20;
    mdl[3] |= 2;
    rdc(2);
    drv(0, 0);
    wr(2, 0);
    wr(3, 2);
    $display("test supply done");
    foreach (codes[i]) begin
      tick(1);
      wr(0, codes[i]);
      rdc(0);
      tick(1);
      c0 = osc_cnt;
      tick(20);
      chk(osc_cnt - c0, 20 * OPS + dlt(codes[i]));
    end
    $display("test trim done");
    results;
  end
endmodule // rtc_trim_and_supply_monitor_tb
`default_nettype wire
